// ---- verilog/spi_exc_handler.sv ----
// SPI target frame checker, reply selector and sticky status flags.
// Overview of operation
// - Register read carries address in bits 12..8, bits 7..0 zero.
// - Register read answered next frame only without framing, readback or invalid errors.
// - Reply chosen by fixed priority from framing error down to modulator over range.
// - Top seven exceptions give error reply, no arming; pulse code off on init/reset.
// - Clock high at select edges, wrong edge count or bad parity is framing error.
// - Nonzero reserved bits in acceleration or read commands are framing errors.
// - Framing error gives framing reply, no arming, pulse code unaffected.
// - Serial output is read back each bit; mismatch sets readback flag.
// - Acceleration request in mismatch frame is dropped with readback reply.
// - Register write in mismatch frame is still done, readback reply follows.
// - Read in mismatch frame is dropped; status read then clears nothing.
// - Readback flag holds until an error-free status read completes.
// - Configuration mismatch gives invalid acceleration reply once, no fault, no arming.
// - Bad write, locked write or bad read gives invalid register reply.
// - Init or reset flag makes acceleration requests error; status read clears reset.
// - CRC, self-test or logic faults set the internal fault flag.
// - CRC fault gives internal error reply until fault flag clears.
// - Locked writable CRC fault clears only by reset; OTP CRC fault also clears only by reset.
// - Self-test fault gives self-test reply; flag kept until status read.
// - Offset over range gives valid data with status 10, one extra frame after.
// - Modulator over range gives valid data with status 10, one extra frame after.
// - First reply after reset is framing error; acceleration invalid until reset cleared.
// - Commands carry odd parity over all sixteen bits, checked here.
// - Acceleration bit picks frame type; direction bit picks read or write.
// - Register write applied after frame end, dropped on framing error.
`timescale 1ns/100ps
`default_nettype none
`include "spi_exc_consts.svh"
module spi_exc_handler #(
  parameter logic [31:0] READ_MASK = `READ_MASK,
  parameter logic [31:0] WRITE_MASK = `WRITE_MASK
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  input wire logic miso_fb_in,
  output logic miso_out,
  output logic miso_oe_out,
  input wire logic cfg_signed_in,
  input wire logic cfg_arm_select_in,
  input wire logic init_lock_in,
  input wire logic init_done_in,
  input wire logic otp_crc_fail_in,
  input wire logic wreg_crc_fail_in,
  input wire logic selftest_fail_in,
  input wire logic logic_fault_in,
  input wire logic offset_over_x_in,
  input wire logic offset_over_y_in,
  input wire logic modulator_over_in,
  input wire logic [9:0] accel_data_in,
  input wire logic [7:0] reg_rd_data_in,
  output logic [1:0] accel_sel_out,
  output logic [4:0] reg_addr_out,
  output logic reg_wr_en_out,
  output logic [7:0] reg_wr_data_out,
  output logic arm_update_out,
  output logic pcm_enable_out,
  output logic [7:0] device_status_register_out
);
  logic sclk_q;
  logic cs_n_q;
  logic mosi_q;
  logic fb_q;
  logic sclk_prev_reg;
  logic cs_prev_reg;
  logic [4:0] cnt_reg;
  logic [15:0] rx_reg;
  logic [15:0] tx_reg;
  logic [15:0] reply_reg;
  logic timing_err_reg;
  logic frame_mis_reg;
  logic sclk_rise;
  logic cs_start;
  logic cs_end;
  logic mis_event;
  logic parity_ok;
  logic field_err;
  logic accel_mismatch;
  logic framing;
  logic is_accel;
  logic is_write;
  logic [4:0] addr;
  logic reg_invalid;
  logic status_read_ok;
  logic accel_ok;
  logic write_ok;
  logic over_now;
  logic over_last;
  logic [1:0] s_bits;
  logic [9:0] payload;
  spi_exc_pkg::reply_kind_t kind;
  logic init_pending_flag_reg;
  logic reset_occurred_flag_reg;
  logic readback_mismatch_flag_reg;
  logic otp_crc_reg;
  logic wreg_crc_reg;
  logic wreg_lock_reg;
  logic selftest_reg;
  logic logic_fault_reg;
  logic internal_fault_flag;
  logic off_x_reg;
  logic off_y_reg;
  logic modulator_overrange_flag_reg;
  logic last_x_reg;
  logic last_y_reg;
  logic last_mod_reg;
  logic [7:0] status_byte;

  function automatic logic [3:0] kind_code(input spi_exc_pkg::reply_kind_t k);
    case (k)
      spi_exc_pkg::REPLY_VALID: kind_code = `CODE_VALID;
      spi_exc_pkg::REPLY_FRAME: kind_code = `CODE_FRAME;
      spi_exc_pkg::REPLY_RDBK: kind_code = `CODE_RDBK;
      spi_exc_pkg::REPLY_INV_ACC: kind_code = `CODE_INV_ACC;
      spi_exc_pkg::REPLY_INV_REG: kind_code = `CODE_INV_REG;
      spi_exc_pkg::REPLY_INT_ERR: kind_code = `CODE_INT_ERR;
      spi_exc_pkg::REPLY_ST_ERR: kind_code = `CODE_ST_ERR;
      default: kind_code = `CODE_REG;
    endcase
  endfunction

  pin_sync #(.WIDTH(4)) u_sync (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .pin_in({sclk_in, cs_n_in, mosi_in, miso_fb_in}),
    .reset_val_in(4'h4),
    .level_out({sclk_q, cs_n_q, mosi_q, fb_q})
  );

  cmd_check u_check (
    .cmd_in(rx_reg),
    .cfg_signed_in(cfg_signed_in),
    .cfg_arm_select_in(cfg_arm_select_in),
    .parity_ok_out(parity_ok),
    .field_err_out(field_err),
    .accel_mismatch_out(accel_mismatch)
  );

  // Edge detection on the accepted pin levels.
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      sclk_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
    end else begin
      sclk_prev_reg <= sclk_q;
      cs_prev_reg <= cs_n_q;
    end
  end

  assign cs_start = cs_prev_reg & ~cs_n_q;
  assign cs_end = ~cs_prev_reg & cs_n_q;
  assign sclk_rise = ~sclk_prev_reg & sclk_q & ~cs_n_q & ~cs_start;
  assign mis_event = sclk_rise & (fb_q != miso_out);

  // Frame shifting: each detected clock rise takes a command bit, checks the bit on the pin
  // and only then launches the next reply bit. The pin pipeline is too slow to answer a
  // falling edge before the host samples, so the bit is moved just after the host's sample.
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      cnt_reg <= 5'h00;
      rx_reg <= 16'h0000;
      tx_reg <= 16'h0000;
      timing_err_reg <= 1'b0;
      frame_mis_reg <= 1'b0;
      miso_out <= 1'b0;
      miso_oe_out <= 1'b0;
    end else if (cs_start) begin
      cnt_reg <= 5'h00;
      timing_err_reg <= sclk_q;
      frame_mis_reg <= 1'b0;
      tx_reg <= reply_reg;
      miso_out <= reply_reg[15];
      miso_oe_out <= 1'b1;
    end else if (!cs_n_q) begin
      if (sclk_rise) begin
        rx_reg <= {rx_reg[14:0], mosi_q};
        if (cnt_reg != `CNT_MAX) begin
          cnt_reg <= cnt_reg + 5'h01;
        end
        if (mis_event) begin
          frame_mis_reg <= 1'b1;
        end
        tx_reg <= {tx_reg[14:0], 1'b0};
        miso_out <= tx_reg[14];
      end
    end else begin
      miso_oe_out <= 1'b0;
    end
  end

  // Decode of the finished command.
  always_comb begin
    is_accel = rx_reg[`CMD_ACC_BIT];
    is_write = ~is_accel & rx_reg[`CMD_DIR_BIT];
    addr = rx_reg[`CMD_ADDR_HI:`CMD_ADDR_LO];
    framing = timing_err_reg | sclk_q | (cnt_reg != `FRAME_BITS)
      | ~parity_ok | field_err;
    if (is_write) begin
      reg_invalid = ~WRITE_MASK[addr] | (init_lock_in & (addr != `ADDR_CTRL));
    end else begin
      reg_invalid = ~READ_MASK[addr];
    end
    over_now = rx_reg[`CMD_DIR_BIT] ? offset_over_y_in : offset_over_x_in;
    over_last = rx_reg[`CMD_DIR_BIT] ? last_y_reg : last_x_reg;
  end

  assign status_read_ok = cs_end & ~framing & ~frame_mis_reg & ~is_accel & ~is_write
    & ~reg_invalid & (addr == `ADDR_STATUS);
  assign write_ok = cs_end & ~framing & is_write & ~reg_invalid;
  assign internal_fault_flag = otp_crc_reg | wreg_crc_reg | selftest_reg | logic_fault_reg;

  // Reply selection by fixed priority.
  always_comb begin
    s_bits = `S_NORMAL;
    payload = 10'h000;
    accel_ok = 1'b0;
    if (framing) begin
      kind = spi_exc_pkg::REPLY_FRAME;
    end else if (frame_mis_reg) begin
      kind = spi_exc_pkg::REPLY_RDBK;
    end else if (is_accel) begin
      if (accel_mismatch | reset_occurred_flag_reg) begin
        kind = spi_exc_pkg::REPLY_INV_ACC;
      end else if (init_pending_flag_reg) begin
        kind = spi_exc_pkg::REPLY_INT_ERR;
      end else if (otp_crc_reg | wreg_crc_reg | logic_fault_reg) begin
        kind = spi_exc_pkg::REPLY_INT_ERR;
      end else if (selftest_reg) begin
        kind = spi_exc_pkg::REPLY_ST_ERR;
      end else begin
        kind = spi_exc_pkg::REPLY_VALID;
        accel_ok = 1'b1;
        payload = accel_data_in;
        if (over_now | over_last | modulator_over_in | last_mod_reg) begin
          s_bits = `S_OVER;
        end
      end
    end else if (reg_invalid) begin
      kind = spi_exc_pkg::REPLY_INV_REG;
    end else begin
      kind = spi_exc_pkg::REPLY_REG;
      if (is_write) begin
        payload = {2'b00, rx_reg[7:0]};
      end else if (addr == `ADDR_STATUS) begin
        payload = {2'b00, status_byte};
      end else begin
        payload = {2'b00, reg_rd_data_in};
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      reply_reg <= `REPLY_RESET;
    end else if (cs_end) begin
      reply_reg <= {kind_code(kind), s_bits, payload};
    end
  end

  // Over-range history for the trailing status frame.
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      last_x_reg <= 1'b0;
      last_y_reg <= 1'b0;
      last_mod_reg <= 1'b0;
    end else if (cs_end & accel_ok) begin
      last_mod_reg <= modulator_over_in;
      if (rx_reg[`CMD_DIR_BIT]) begin
        last_y_reg <= offset_over_y_in;
      end else begin
        last_x_reg <= offset_over_x_in;
      end
    end
  end

  // Outputs towards the register array and the arming logic.
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      accel_sel_out <= 2'h0;
      reg_addr_out <= 5'h00;
      reg_wr_en_out <= 1'b0;
      reg_wr_data_out <= 8'h00;
      arm_update_out <= 1'b0;
      pcm_enable_out <= 1'b0;
      device_status_register_out <= 8'h00;
    end else begin
      accel_sel_out <= {rx_reg[`CMD_DIR_BIT], rx_reg[`CMD_OC_BIT]};
      reg_addr_out <= addr;
      reg_wr_en_out <= write_ok;
      reg_wr_data_out <= rx_reg[7:0];
      arm_update_out <= cs_end & accel_ok;
      pcm_enable_out <= ~(init_pending_flag_reg | reset_occurred_flag_reg);
      device_status_register_out <= status_byte;
    end
  end

  assign status_byte = {init_pending_flag_reg, reset_occurred_flag_reg, internal_fault_flag,
    readback_mismatch_flag_reg, modulator_overrange_flag_reg, off_x_reg, off_y_reg, 1'b0};

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      init_pending_flag_reg <= 1'b1;
      reset_occurred_flag_reg <= 1'b1;
    end else begin
      if (init_done_in) begin
        init_pending_flag_reg <= 1'b0;
      end
      if (status_read_ok) begin
        reset_occurred_flag_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      readback_mismatch_flag_reg <= 1'b0;
    end else if (mis_event) begin
      readback_mismatch_flag_reg <= 1'b1;
    end else if (status_read_ok) begin
      readback_mismatch_flag_reg <= 1'b0;
    end
  end

  // Fault sources behind the internal fault flag; a present fault wins over a clear.
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      otp_crc_reg <= 1'b0;
      wreg_crc_reg <= 1'b0;
      wreg_lock_reg <= 1'b0;
      selftest_reg <= 1'b0;
      logic_fault_reg <= 1'b0;
    end else begin
      if (otp_crc_fail_in) begin
        otp_crc_reg <= 1'b1;
      end
      if (wreg_crc_fail_in) begin
        wreg_crc_reg <= 1'b1;
        if (init_lock_in) begin
          wreg_lock_reg <= 1'b1;
        end
      end else if (status_read_ok & ~wreg_lock_reg) begin
        wreg_crc_reg <= 1'b0;
      end
      if (selftest_fail_in) begin
        selftest_reg <= 1'b1;
      end else if (status_read_ok) begin
        selftest_reg <= 1'b0;
      end
      if (logic_fault_in) begin
        logic_fault_reg <= 1'b1;
      end else if (status_read_ok) begin
        logic_fault_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      off_x_reg <= 1'b0;
      off_y_reg <= 1'b0;
      modulator_overrange_flag_reg <= 1'b0;
    end else begin
      off_x_reg <= offset_over_x_in | (off_x_reg & ~status_read_ok);
      off_y_reg <= offset_over_y_in | (off_y_reg & ~status_read_ok);
      modulator_overrange_flag_reg <= modulator_over_in
        | (modulator_overrange_flag_reg & ~status_read_ok);
    end
  end

  a_first_reply_frame: assert property (@(posedge core_clk_in)
    $rose(reset_n_in) |-> reply_reg[15:12] == `CODE_FRAME)
    else $error("first reply after reset is not the framing reply");
  a_framing_reply: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    cs_end && framing |=> reply_reg[15:12] == `CODE_FRAME && !arm_update_out)
    else $error("framing error not answered with framing reply");
  a_readback_reply: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    cs_end && !framing && frame_mis_reg |=> reply_reg[15:12] == `CODE_RDBK)
    else $error("readback mismatch frame not answered with readback reply");
  a_invalid_reg_reply: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    cs_end && !framing && !frame_mis_reg && !is_accel && reg_invalid
    |=> reply_reg[15:12] == `CODE_INV_REG)
    else $error("invalid register request not answered as such");
  a_arm_only_valid: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    arm_update_out |-> $past(cs_end) && !$past(framing) && !$past(frame_mis_reg)
      && !$past(reset_occurred_flag_reg) && reply_reg[15:12] == `CODE_VALID)
    else $error("arming updated on an error reply");
  a_write_after_frame: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    reg_wr_en_out |-> $past(cs_end) && !$past(framing) && $past(is_write))
    else $error("register write without a clean finished write frame");
  a_readback_hold: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    readback_mismatch_flag_reg && !status_read_ok |=> readback_mismatch_flag_reg)
    else $error("readback flag cleared without status read");
  a_pcm_gate: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    init_pending_flag_reg || reset_occurred_flag_reg |=> !pcm_enable_out)
    else $error("pulse code enabled while init or reset flag set");
  a_otp_sticky: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    otp_crc_reg |=> otp_crc_reg && device_status_register_out[5])
    else $error("OTP CRC fault cleared");
  a_over_status: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    cs_end && accel_ok && modulator_over_in |=> reply_reg[11:10] == `S_OVER)
    else $error("over range status bits not set");
endmodule
`default_nettype wire

// ---- verilog/spi_exc_consts.svh ----
// Constants for the SPI exception handler: frame fields, codes and addresses.
`ifndef SPI_EXC_CONSTS_SVH
`define SPI_EXC_CONSTS_SVH
`define FRAME_BITS 5'h10
`define CNT_MAX 5'h1F
`define CMD_PAR_BIT 15
`define CMD_ACC_BIT 14
`define CMD_DIR_BIT 13
`define CMD_OC_BIT 12
`define CMD_ADDR_HI 12
`define CMD_ADDR_LO 8
`define CMD_SD_BIT 2
`define CMD_ARM_BIT 1
`define CODE_VALID 4'h1
`define CODE_FRAME 4'h2
`define CODE_RDBK 4'h3
`define CODE_INV_ACC 4'h4
`define CODE_INV_REG 4'h5
`define CODE_INT_ERR 4'h6
`define CODE_ST_ERR 4'h7
`define CODE_REG 4'h8
`define S_NORMAL 2'h0
`define S_OVER 2'h2
`define ADDR_CTRL 5'h01
`define ADDR_CFG 5'h02
`define ADDR_STATUS 5'h03
`define READ_MASK 32'h0000_00FF
`define WRITE_MASK 32'h0000_0076
`define REPLY_RESET 16'h2000
`endif

// ---- verilog/spi_exc_pkg.sv ----
// Types shared by the SPI exception handler.
package spi_exc_pkg;
  typedef enum logic [3:0] {
    REPLY_VALID, REPLY_FRAME, REPLY_RDBK, REPLY_INV_ACC,
    REPLY_INV_REG, REPLY_INT_ERR, REPLY_ST_ERR, REPLY_REG
  } reply_kind_t;
endpackage

// ---- verilog/pin_sync.sv ----
// Three-stage pin synchroniser that accepts a level once stages two and three agree.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] reset_val_in,
  output logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  always_ff @(posedge core_clk_in) begin
    s1_reg <= pin_in;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      level_out <= reset_val_in;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          level_out[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- verilog/cmd_check.sv ----
// Combinational field, parity and configuration checks on a received command.
`timescale 1ns/100ps
`default_nettype none
`include "spi_exc_consts.svh"
module cmd_check (
  input wire logic [15:0] cmd_in,
  input wire logic cfg_signed_in,
  input wire logic cfg_arm_select_in,
  output logic parity_ok_out,
  output logic field_err_out,
  output logic accel_mismatch_out
);
  logic is_accel;

  always_comb begin
    is_accel = cmd_in[`CMD_ACC_BIT];
    parity_ok_out = ^cmd_in;
    if (is_accel) begin
      field_err_out = cmd_in[15] | (|cmd_in[11:3]);
    end else if (!cmd_in[`CMD_DIR_BIT]) begin
      field_err_out = |cmd_in[7:0];
    end else begin
      field_err_out = 1'b0;
    end
    accel_mismatch_out = is_accel &
      ((cmd_in[`CMD_SD_BIT] != cfg_signed_in) | (cmd_in[`CMD_ARM_BIT] != cfg_arm_select_in));
  end
endmodule
`default_nettype wire

// ---- dv/spi_host_model.sv ----
// Host-side SPI master model that frames one command and captures the reply.
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  input wire logic miso_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic mosi_out
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // Mode 0 master; edges sets the clock count and hi leaves the clock high as select asserts.
  task automatic frame(input logic [15:0] cmd, input int edges, input logic hi,
                       output logic [15:0] rsp);
    rsp = 16'h0000;
    #13 sclk_out = hi;
    #400 cs_n_out = 1'b0;
    #200 sclk_out = 1'b0;
    for (int i = 0; i < edges; i++) begin
      mosi_out = cmd[15 - (i % 16)];
      #400 sclk_out = 1'b1;
      if (i < 16) begin
        rsp[15 - i] = miso_in;
      end
      #400 sclk_out = 1'b0;
    end
    #400 cs_n_out = 1'b1;
    // A released data line shows the opposite level so that a stale bit never looks valid.
    mosi_out = ~mosi_out;
    #800;
  endtask
endmodule
`default_nettype wire

// ---- dv/sensor_spi_exception_handler_bench.sv ----
// Self-checking bench for the SPI exception handler against the host model.
`timescale 1ns/100ps
`default_nettype none
`include "spi_exc_consts.svh"
module sensor_spi_exception_handler_bench;
  logic clk = 1'b0, rst_n = 1'b0, flip = 1'b0, sd = 1'b0, am = 1'b0, lock = 1'b0;
  logic idn = 1'b0, otp = 1'b0, wcrc = 1'b0, st = 1'b0, lf = 1'b0;
  logic ox = 1'b0, oy = 1'b0, mod = 1'b0;
  logic sclk, cs_n, mosi, miso, oe, wr_en, arm, pcm;
  logic [9:0] acc = 10'h000;
  logic [4:0] addr;
  logic [7:0] wd, stat, wdv;
  logic [15:0] rsp;
  logic [15:0] bad [7];
  int num_errors = 0, checked = 0, arms = 0, wrs = 0, a0;
  // The pin floats when not driven, so the host sees the inverse of the last bit.
  wire logic line = oe ? miso : ~miso;
  wire logic fb = line ^ flip;
  wire logic [7:0] rd = {3'h5, addr};

  spi_exc_handler u_dut (
    .core_clk_in(clk), .reset_n_in(rst_n), .sclk_in(sclk), .cs_n_in(cs_n),
    .mosi_in(mosi), .miso_fb_in(fb), .miso_out(miso), .miso_oe_out(oe),
    .cfg_signed_in(sd), .cfg_arm_select_in(am), .init_lock_in(lock),
    .init_done_in(idn), .otp_crc_fail_in(otp), .wreg_crc_fail_in(wcrc),
    .selftest_fail_in(st), .logic_fault_in(lf), .offset_over_x_in(ox),
    .offset_over_y_in(oy), .modulator_over_in(mod), .accel_data_in(acc),
    .reg_rd_data_in(rd), .accel_sel_out(), .reg_addr_out(addr),
    .reg_wr_en_out(wr_en), .reg_wr_data_out(wd), .arm_update_out(arm),
    .pcm_enable_out(pcm), .device_status_register_out(stat)
  );
  spi_host_model u_host (.miso_in(line), .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi));

  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (arm === 1'b1) arms++;
    if (wr_en === 1'b1) wrs++;
  end

  function automatic logic [15:0] ac(input logic ch, input logic [1:0] cf);
    logic [15:0] w;
    w = {2'b01, ch, 1'b0, 9'h000, cf, 1'b0};
    w[0] = ~^w[15:1];
    return w;
  endfunction
  function automatic logic [15:0] rc(input logic wr, input logic [4:0] a, input logic [7:0] d);
    logic [15:0] w;
    w = {2'b00, wr, a, d};
    w[15] = ~^w[14:0];
    return w;
  endfunction
  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask
  // Runs one frame and checks the reply code earned by the frame before it; code 0 skips.
  task automatic fr(input logic [15:0] c, input logic [3:0] code, input int n = 16,
                    input logic hi = 1'b0);
    u_host.frame(c, n, hi, rsp);
    if (code != 4'h0) chk("reply code", 16'(code), 16'(rsp[15:12]));
    @(posedge clk);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #3000000;
    num_errors++;
    report_and_stop;
  end

  initial begin
    void'($urandom(32'hC6A3));
    bad = '{ac(0, 0) ^ 16'h0001, ac(0, 0) ^ 16'h8001, ac(0, 0) ^ 16'h0021, rc(0, 3, 8'h01),
            rc(1, 2, 8'h33), rc(1, 2, 8'h33), ac(0, 0)};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("status", 16'h00C0, 16'(stat));
    chk("pcm enable", 16'h0000, 16'(pcm));
    idn <= 1'b1;
    fr(ac(0, 0), `CODE_FRAME);
    fr(rc(0, 3, 0), `CODE_INV_ACC);
    chk("arm count", 16'h0000, 16'(arms));
    acc <= 10'($urandom);
    fr(ac(1, 0), `CODE_REG);
    chk("status read", 16'h0040, 16'(rsp[7:0]));
    chk("pcm enable", 16'h0001, 16'(pcm));
    fr(ac(0, 0), `CODE_VALID);
    chk("accel data", 16'(acc), 16'(rsp[9:0]));
    chk("arm count", 16'h0002, 16'(arms));
    done("reset");
    for (int k = 0; k < 7; k++) begin
      fr(bad[k], k == 0 ? `CODE_VALID : `CODE_FRAME, k == 4 ? 15 : k == 5 ? 17 : 16, k == 6);
    end
    fr(ac(0, 0), `CODE_FRAME);
    chk("arm count", 16'h0003, 16'(arms));
    chk("write count", 16'h0000, 16'(wrs));
    done("framing");
    flip <= 1'b1;
    wdv = 8'($urandom);
    fr(rc(1, 2, wdv), `CODE_VALID);
    chk("write count", 16'h0001, 16'(wrs));
    chk("write data", 16'(wdv), 16'(wd));
    chk("mismatch flag", 16'h0001, 16'(stat[4]));
    flip <= 1'b0;
    fr(ac(0, 0), `CODE_RDBK);
    a0 = arms;
    flip <= 1'b1;
    fr(ac(0, 0), `CODE_VALID);
    fr(rc(0, 3, 0), `CODE_RDBK);
    flip <= 1'b0;
    fr(ac(0, 0), `CODE_RDBK);
    chk("arm count", 16'(a0 + 1), 16'(arms));
    chk("mismatch flag", 16'h0001, 16'(stat[4]));
    fr(rc(0, 3, 0), `CODE_VALID);
    fr(ac(0, 0), `CODE_REG);
    chk("status read", 16'h0010, 16'(rsp[7:0] & 8'h10));
    chk("mismatch flag", 16'h0000, 16'(stat[4]));
    done("readback");
    fr(ac(0, 2'b10), `CODE_VALID);
    fr(ac(0, 2'b01), `CODE_INV_ACC);
    fr(ac(0, 0), `CODE_INV_ACC);
    fr(rc(1, 3, 0), `CODE_VALID);
    chk("fault flag", 16'h0000, 16'(stat[5]));
    fr(rc(0, 9, 0), `CODE_INV_REG);
    lock <= 1'b1;
    fr(rc(1, 2, 8'h5A), `CODE_INV_REG);
    fr(rc(1, 1, 8'h01), `CODE_INV_REG);
    lock <= 1'b0;
    fr(rc(0, 2, 0), `CODE_REG);
    chk("write count", 16'h0002, 16'(wrs));
    st <= 1'b1;
    fr(ac(0, 0), `CODE_REG);
    chk("read data", 16'h00A2, 16'(rsp[7:0]));
    done("requests");
    a0 = arms;
    fr(ac(0, 0) ^ 16'h0001, `CODE_ST_ERR);
    st <= 1'b0;
    fr(rc(0, 3, 0), `CODE_FRAME);
    chk("arm count", 16'(a0), 16'(arms));
    fr(ac(0, 0), `CODE_REG);
    chk("status read", 16'h0020, 16'(rsp[7:0] & 8'h20));
    chk("fault flag", 16'h0000, 16'(stat[5]));
    done("self test");
    for (int k = 0; k < 3; k++) begin
      {mod, oy, ox} <= 3'(1 << k);
      a0 = arms;
      for (int f = 0; f < 5; f++) begin
        if (f == 2) begin
          {mod, oy, ox} <= 3'h0;
        end
        acc <= 10'($urandom);
        fr(ac(k == 1, 0), `CODE_VALID);
        chk("status field", (f == 0 || f == 4) ? 16'h0 : 16'h2, 16'(rsp[11:10]));
      end
      chk("arm count", 16'(a0 + 5), 16'(arms));
    end
    chk("range flags", 16'h000E, 16'(stat & 8'h0E));
    chk("pcm enable", 16'h0001, 16'(pcm));
    done("over range");
    otp <= 1'b1;
    fr(ac(0, 0), `CODE_VALID);
    fr(rc(0, 3, 0), `CODE_INT_ERR);
    otp <= 1'b0;
    fr(ac(0, 0), `CODE_REG);
    fr(ac(0, 0), `CODE_INT_ERR);
    chk("fault flag", 16'h0001, 16'(stat[5]));
    done("crc fault");
    // A second reset, then a writable-register fault under the lock that a read must not clear.
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    lock <= 1'b1;
    wcrc <= 1'b1;
    repeat (3) @(posedge clk);
    wcrc <= 1'b0;
    fr(rc(0, 3, 0), `CODE_FRAME);
    fr(rc(0, 3, 0), `CODE_REG);
    chk("status read", 16'h0060, 16'(rsp[7:0]));
    chk("status", 16'h0020, 16'(stat));
    done("locked crc fault");
    report_and_stop;
  end
endmodule
`default_nettype wire
